// ==== core/sbp_sram_port.sv ====
`timescale 1ns/10ps
// Function
// - load low, direction low on K rise starts write; data at K(t+1), K#(t+1)
// - load low, direction high starts read; words at C#(t+1) then C(t+2)
// - after power-up deselected, data outputs high impedance
// - wide style: first word at latched address, second with address LSB inverted
// - narrow style: burst always offset zero then one of the location
// - write data captured on rising edges of K and K#, one word each
// - read data launched on output clock rises, or K pair in single-clock mode
// - lane 0 select low, lane 1 high: only lower lane written
// - lane 0 select high, lane 1 low: only upper lane written
// - both selects high write nothing; both low write whole word
// - single lane: low select writes word, high select suppresses it
// - lane selects sampled separately for each data word
// - deselected reads finish pending burst, then tri-state after next C rise
// - delay loop disabled gives one-cycle read latency
module sbp_sram_port #(
  parameter int DATA_W = sbp_pkg::DATA_W_DEF,
  parameter int LANES = sbp_pkg::LANES_DEF,
  parameter int ADDR_W = sbp_pkg::ADDR_W_DEF,
  parameter bit WIDE_BURST = sbp_pkg::WIDE_BURST_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic k_i,
  input wire logic k_n_i,
  input wire logic c_i,
  input wire logic c_n_i,
  input wire logic load_strobe_n_i,
  input wire logic read_not_write_i,
  input wire logic delay_loop_disable_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] d_i,
  input wire logic [LANES-1:0] lane_write_sel_n_i,
  output logic [DATA_W-1:0] q_o,
  output logic q_oe_o,
  output logic echo_strobe_o,
  output logic echo_strobe_n_o
);
  localparam int LANE_W = DATA_W / LANES;
  localparam int IDX_W = ADDR_W + 1;
  localparam int ENTRIES = 1 << IDX_W;
  localparam int IN_W = 7 + ADDR_W + DATA_W + LANES;

  if (LANES < 1 || DATA_W % LANES != 0 || ADDR_W < 1 || ADDR_W > 16) begin : g_bad_cfg
    $error("sbp_sram_port: unsupported width or lane configuration");
  end

  // ****************************************
  // input synchronisers and edge finders
  // ****************************************
  logic [IN_W-1:0] in_raw;
  logic [IN_W-1:0] sync1;
  logic [IN_W-1:0] sync2;
  logic [3:0] clk_d;
  logic [1:0] strap_cnt;
  logic strap_done;
  logic single_clk;
  logic [3:0] clk_s;
  logic s_ld_n;
  logic s_rw;
  logic s_dll_off;
  logic [ADDR_W-1:0] s_addr;
  logic [DATA_W-1:0] s_d;
  logic [LANES-1:0] s_sel_n;
  logic k_rise;
  logic kn_rise;
  logic p_edge;
  logic n_edge;

  assign in_raw = {k_i, k_n_i, c_i, c_n_i, load_strobe_n_i, read_not_write_i,
                   delay_loop_disable_i, addr_i, d_i, lane_write_sel_n_i};
  assign clk_s = sync2[IN_W-1 -: 4];
  assign s_ld_n = sync2[IN_W-5];
  assign s_rw = sync2[IN_W-6];
  assign s_dll_off = sync2[IN_W-7];
  assign s_addr = sync2[DATA_W+LANES +: ADDR_W];
  assign s_d = sync2[LANES +: DATA_W];
  assign s_sel_n = sync2[LANES-1:0];

  assign k_rise = strap_done & clk_s[3] & ~clk_d[3];
  assign kn_rise = strap_done & clk_s[2] & ~clk_d[2];
  // output reference is C pair, or K pair in single-clock mode
  assign p_edge = single_clk ? k_rise : (strap_done & clk_s[1] & ~clk_d[1]);
  assign n_edge = single_clk ? kn_rise : (strap_done & clk_s[0] & ~clk_d[0]);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= '0;
      sync2 <= '0;
      clk_d <= 4'h0;
    end else begin
      sync1 <= in_raw;
      sync2 <= sync1;
      clk_d <= clk_s;
    end
  end

  // single-clock strap: C and C# both high once inputs settle after reset
  logic [1:0] next_strap_cnt;
  logic next_strap_done;
  logic next_single_clk;

  always_comb begin
    next_strap_cnt = strap_cnt;
    next_strap_done = strap_done;
    next_single_clk = single_clk;
    if (!strap_done) begin
      if (strap_cnt == sbp_pkg::STRAP_WAIT) begin
        next_strap_done = 1'b1;
        next_single_clk = clk_s[1] & clk_s[0];
      end else begin
        next_strap_cnt = strap_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_cnt <= 2'h0;
      strap_done <= 1'b0;
      single_clk <= sbp_pkg::SINGLE_CLK_RST;
    end else begin
      strap_cnt <= next_strap_cnt;
      strap_done <= next_strap_done;
      single_clk <= next_single_clk;
    end
  end

  // ****************************************
  // command slots advanced by K rises
  // ****************************************
  sbp_pkg::sbp_op_t op_s1;
  sbp_pkg::sbp_op_t op_s2;
  sbp_pkg::sbp_op_t op_s3;
  logic [IDX_W-1:0] base_s1;
  logic [IDX_W-1:0] base_s2;
  logic [IDX_W-1:0] base_s3;
  sbp_pkg::sbp_op_t next_op_s1;
  sbp_pkg::sbp_op_t next_op_s2;
  sbp_pkg::sbp_op_t next_op_s3;
  logic [IDX_W-1:0] next_base_s1;
  logic [IDX_W-1:0] next_base_s2;
  logic [IDX_W-1:0] next_base_s3;
  logic [IDX_W-1:0] addr_base;

  // second word always sits at base with low bit flipped
  assign addr_base = WIDE_BURST ? {1'b0, s_addr} : {s_addr, 1'b0};

  always_comb begin
    next_op_s1 = op_s1;
    next_op_s2 = op_s2;
    next_op_s3 = op_s3;
    next_base_s1 = base_s1;
    next_base_s2 = base_s2;
    next_base_s3 = base_s3;
    if (k_rise) begin
      if (s_ld_n) begin
        next_op_s1 = sbp_pkg::OP_NOP;
      end else if (s_rw) begin
        next_op_s1 = sbp_pkg::OP_RD;
      end else begin
        next_op_s1 = sbp_pkg::OP_WR;
      end
      next_base_s1 = addr_base;
      next_op_s2 = op_s1;
      next_base_s2 = base_s1;
      next_op_s3 = op_s2;
      next_base_s3 = base_s2;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      op_s1 <= sbp_pkg::OP_NOP;
      op_s2 <= sbp_pkg::OP_NOP;
      op_s3 <= sbp_pkg::OP_NOP;
      base_s1 <= '0;
      base_s2 <= '0;
      base_s3 <= '0;
    end else begin
      op_s1 <= next_op_s1;
      op_s2 <= next_op_s2;
      op_s3 <= next_op_s3;
      base_s1 <= next_base_s1;
      base_s2 <= next_base_s2;
      base_s3 <= next_base_s3;
    end
  end

  // ****************************************
  // array with per-lane write mask
  // ****************************************
  logic [DATA_W-1:0] mem [ENTRIES];
  logic [DATA_W-1:0] next_mem [ENTRIES];
  logic [DATA_W-1:0] lane_mask;
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;

  // word 0 at K(t+1) rise, word 1 at K#(t+1) rise
  assign wr_en = (k_rise && op_s1 == sbp_pkg::OP_WR) ||
                 (kn_rise && op_s2 == sbp_pkg::OP_WR);
  assign wr_idx = k_rise ? base_s1 : (base_s2 ^ {{(IDX_W-1){1'b0}}, 1'b1});

  // selects taken fresh at each data edge
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    assign lane_mask[l*LANE_W +: LANE_W] = {LANE_W{~s_sel_n[l]}};
  end

  always_comb begin
    next_mem = mem;
    if (wr_en) begin
      next_mem[wr_idx] = (mem[wr_idx] & ~lane_mask) | (s_d & lane_mask);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < ENTRIES; i++) begin
        mem[i] <= '0;
      end
    end else begin
      mem <= next_mem;
    end
  end

  // ****************************************
  // read launch on output reference edges
  // ****************************************
  sbp_pkg::sbp_op_t p_op;
  logic [IDX_W-1:0] p_idx;
  logic [IDX_W-1:0] n_idx;
  logic [DATA_W-1:0] next_q;
  logic next_q_oe;
  logic next_echo;

  // slot view at a coincident K rise uses the value being shifted in
  always_comb begin
    if (s_dll_off) begin
      p_op = k_rise ? op_s1 : op_s2;
      p_idx = k_rise ? base_s1 : base_s2;
      n_idx = base_s2 ^ {{(IDX_W-1){1'b0}}, 1'b1};
    end else begin
      p_op = k_rise ? op_s2 : op_s3;
      p_idx = (k_rise ? base_s2 : base_s3) ^ {{(IDX_W-1){1'b0}}, 1'b1};
      n_idx = base_s2;
    end
  end

  always_comb begin
    next_q = q_o;
    next_q_oe = q_oe_o;
    next_echo = echo_strobe_o;
    if (p_edge) begin
      next_echo = 1'b1;
      if (p_op == sbp_pkg::OP_RD) begin
        next_q = mem[p_idx];
        next_q_oe = 1'b1;
      end else begin
        next_q_oe = 1'b0;
      end
    end else if (n_edge) begin
      next_echo = 1'b0;
      if (op_s2 == sbp_pkg::OP_RD) begin
        next_q = mem[n_idx];
        next_q_oe = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_o <= '0;
      q_oe_o <= sbp_pkg::Q_OE_RST;
      echo_strobe_o <= sbp_pkg::ECHO_RST;
      echo_strobe_n_o <= ~sbp_pkg::ECHO_RST;
    end else begin
      q_o <= next_q;
      q_oe_o <= next_q_oe;
      echo_strobe_o <= next_echo;
      echo_strobe_n_o <= ~next_echo;
    end
  end
endmodule

// ==== core/sbp_pkg.sv ====
package sbp_pkg;
  // ****************************************
  // operation codes held per K-cycle slot
  // ****************************************
  typedef enum logic [2:0] {
    OP_NOP = 3'h1,
    OP_RD = 3'h2,
    OP_WR = 3'h4
  } sbp_op_t;

  // ****************************************
  // defaults and timing counts
  // ****************************************
  localparam int DATA_W_DEF = 18;
  localparam int LANES_DEF = 2;
  localparam int ADDR_W_DEF = 4;
  localparam bit WIDE_BURST_DEF = 1'b1;
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic Q_OE_RST = 1'b0;
  localparam logic ECHO_RST = 1'b0;
  localparam logic SINGLE_CLK_RST = 1'b0;
endpackage

// ==== testbench/sbp_sram_port_props.sv ====
`timescale 1ns/10ps
module sbp_sram_port_chk #(
  parameter int DATA_W = 18
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic k_i,
  input wire logic k_n_i,
  input wire logic load_strobe_n_i,
  input wire logic read_not_write_i,
  input wire logic [DATA_W-1:0] q_o,
  input wire logic q_oe_o,
  input wire logic echo_strobe_o,
  input wire logic echo_strobe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_echo_pair: assert property (echo_strobe_n_o != echo_strobe_o)
    else $error("echo pair not inverse");
  chk_reset_quiet: assert property ($fell(rst_i) |-> !q_oe_o [*4])
    else $error("enable after reset");
  chk_data_enable: assert property (!$stable(q_o) |-> q_oe_o)
    else $error("data moved while released");
  chk_read_answer: assert property ($rose(k_i) && !load_strobe_n_i && read_not_write_i
    |-> ##[8:17] q_oe_o) else $error("read not answered");
  chk_write_quiet: assert property ($rose(k_i) && !load_strobe_n_i && !read_not_write_i
    && !q_oe_o |-> !q_oe_o [*8]) else $error("write drove outputs");
  chk_echo_rise: assert property ($rose(k_i) |-> ##[1:4] echo_strobe_o)
    else $error("echo not set");
  chk_echo_fall: assert property ($rose(k_n_i) |-> ##[1:4] !echo_strobe_o)
    else $error("echo not cleared");
  chk_burst_hold: assert property ($rose(q_oe_o) |-> q_oe_o [*6])
    else $error("burst cut short");
endmodule
bind sbp_sram_port sbp_sram_port_chk #(.DATA_W(DATA_W)) chk_u (.clk_i, .rst_i, .k_i, .k_n_i,
  .load_strobe_n_i, .read_not_write_i, .q_o, .q_oe_o, .echo_strobe_o, .echo_strobe_n_o);

// ==== testbench/sbp_ctl_model.sv ====
`timescale 1ns/10ps
module sbp_ctl_model (
  input wire logic run_i,
  input wire logic sep_c_i,
  output logic k_o,
  output logic k_n_o,
  output logic c_o,
  output logic c_n_o
);
  // C follows K; C# parked low while stopped selects separate output pair
  assign c_o = k_o;
  assign c_n_o = sep_c_i ? ~k_o : 1'b1;
  initial begin
    {k_o, k_n_o} = 2'h3;
    forever begin
      wait (run_i === 1'b1);
      #13;
      while (run_i === 1'b1) begin
        #100 {k_o, k_n_o} = 2'h1;
        #100 {k_o, k_n_o} = 2'h2;
      end
      k_n_o = 1'b1;
    end
  end
endmodule

// ==== testbench/test_sbp_sram_port.sv ====
`timescale 1ns/10ps
module test_sbp_sram_port;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1, run = 1'b0, load_n = 1'b1, rw = 1'b0, dll_off = 1'b0;
  logic k, k_n, c, c_n, oe;
  logic [3:0] addr = 4'h0;
  logic [17:0] d = 18'h0;
  logic [1:0] sel_n = 2'h3;
  logic [17:0] q;
  logic [8:0] q9;
  logic oe9, echo, echo_n, sep_c = 1'b0;
  int err_count = 0, n_tests = 0;
  sbp_ctl_model ctl (.run_i(run), .sep_c_i(sep_c), .k_o(k), .k_n_o(k_n), .c_o(c),
    .c_n_o(c_n));
  sbp_sram_port dut (.clk_i(clk_i), .rst_i(rst_i), .k_i(k), .k_n_i(k_n), .c_i(c), .c_n_i(c_n),
    .load_strobe_n_i(load_n), .read_not_write_i(rw), .delay_loop_disable_i(dll_off),
    .addr_i(addr), .d_i(d), .lane_write_sel_n_i(sel_n), .q_o(q), .q_oe_o(oe),
    .echo_strobe_o(echo), .echo_strobe_n_o(echo_n));
  // nine-bit single-lane narrow configuration on the same link
  sbp_sram_port #(.DATA_W(9), .LANES(1), .WIDE_BURST(1'b0)) dut_nine (
    .clk_i(clk_i), .rst_i(rst_i), .k_i(k), .k_n_i(k_n), .c_i(c), .c_n_i(c_n),
    .load_strobe_n_i(load_n), .read_not_write_i(rw), .delay_loop_disable_i(dll_off),
    .addr_i(addr), .d_i(d[8:0]), .lane_write_sel_n_i(sel_n[0]), .q_o(q9), .q_oe_o(oe9),
    .echo_strobe_o(), .echo_strobe_n_o());
  initial forever #12.5 clk_i = ~clk_i;
  task results;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task krise;
    do @(posedge clk_i); while (k !== 1'b0);
    do @(posedge clk_i); while (k !== 1'b1);
  endtask
  // command set up in the low half, held over the rise
  task cmd(input logic r, input logic [3:0] a);
    krise();
    repeat (5) @(posedge clk_i);
    load_n <= 1'b0;
    rw <= r;
    addr <= a;
    krise();
    load_n <= 1'b1;
  endtask
  task wr(input logic [3:0] a, input logic [17:0] d0, d1, input logic [1:0] s0, s1);
    cmd(1'b0, a);
    d <= d0;
    sel_n <= s0;
    krise();
    d <= d1;
    sel_n <= s1;
    krise();
    d <= ~d1;
  endtask
  task rd(input logic [3:0] a, input logic [17:0] e0, e1, input logic [8:0] n0, n1);
    cmd(1'b1, a);
    repeat (dll_off ? 12 : 16) @(posedge clk_i);
    chk("word0", q, e0);
    chk("nine word0", {9'h0, q9}, {9'h0, n0});
    chk("enable", {16'h0, oe, oe9}, 18'h3);
    chk("echo", {16'h0, echo, echo_n}, dll_off ? 18'h2 : 18'h1);
    repeat (4) @(posedge clk_i);
    chk("word1", q, e1);
    chk("nine word1", {9'h0, q9}, {9'h0, n1});
    repeat (dll_off ? 4 : 8) @(posedge clk_i);
    chk("release", {16'h0, oe, oe9}, 18'h0);
  endtask
  task t_full_word;
    wr(4'h2, 18'h2A5C3, 18'h15A3C, 2'h0, 2'h0);
    rd(4'h2, 18'h2A5C3, 18'h15A3C, 9'h1C3, 9'h03C);
    rd(4'h3, 18'h15A3C, 18'h2A5C3, 9'h000, 9'h000);
  endtask
  task t_lane_mask;
    wr(4'h5, 18'h3FFFF, 18'h3FFFF, 2'h2, 2'h1);
    rd(4'h5, 18'h001FF, 18'h3FE00, 9'h1FF, 9'h000);
    wr(4'h6, 18'h12345, 18'h0ABCD, 2'h3, 2'h0);
    rd(4'h6, 18'h00000, 18'h0ABCD, 9'h000, 9'h1CD);
  endtask
  task t_dll_off;
    wr(4'h2, 18'h00000, 18'h00000, 2'h1, 2'h2);
    dll_off <= 1'b1;
    rd(4'h2, 18'h001C3, 18'h15A00, 9'h1C3, 9'h000);
  endtask
  // mid-run reset with C# low at the strap selects the separate output clocks
  task t_split_clock;
    run <= 1'b0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b1;
    sep_c <= 1'b1;
    dll_off <= 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    run <= 1'b1;
    wr(4'h9, 18'h0F0F0, 18'h30303, 2'h0, 2'h0);
    rd(4'h8, 18'h30303, 18'h0F0F0, 9'h000, 9'h000);
    rd(4'h9, 18'h0F0F0, 18'h30303, 9'h0F0, 9'h103);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    run <= 1'b1;
    t_full_word();
    t_lane_mask();
    t_dll_off();
    t_split_clock();
    results();
  end
  initial begin
    repeat (4000) @(posedge clk_i);
    err_count++;
    results();
  end
endmodule
